// [verilog/bbs_sequencer.sv]
// module: billboard mode sequencer, detach/reattach control with two detach timers
//
// What this block does
// - the selected failure input is active low and a low level activates billboard behaviour.
// - control bits 5 to 1 pick the failure input pin, 01010 by default, with code 01001 reserved.
// - control bit 0 enables the feature when 1 and disables it when 0.
// - the control byte resets to 0x14.
// - a low failure input first forces the internal function off the hub port.
// - after that detach the function reconnects with billboard descriptors of version 1.1.
// - timer A starts when the host assigns the billboard function an address, 20 s by default.
// - billboard is exposed only on failure and reports configuration result 00b.
// - an alternate-mode string request is answered and starts timer B, 20 s by default.
// - expiry of either timer forces the function off the hub port again.
// - after that detach the function reconnects with its normal descriptors.
// - timer A is a 16-bit count of 10 ms units whose low byte resets to D0h.
// - the billboard message text comes from one-time-programmable memory; this block holds no message text or memory of its own.
// - the timer A high byte has its own address and resets to 07h.
// - timer B has its own low and high bytes in 10 ms units with the same detach on expiry.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module bbs_sequencer
    import bbs_pkg::*;
#(
    parameter int TICK_CYCLES   = BBS_TICK_CYCLES,
    parameter int DETACH_CYCLES = BBS_DETACH_CYCLES
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset,
    // register port
    input  wire logic [16:0]              address,
    input  wire logic [7:0]               write_data,
    input  wire logic                     write_strobe,
    input  wire logic                     read_strobe,
    output logic      [7:0]               read_data,
    // general purpose pins, selectable failure input
    input  wire logic [BBS_PIN_COUNT-1:0] gpio_in,
    // events from the internal function
    input  wire logic                     address_assigned,
    input  wire logic                     alt_string_request,
    // attach and descriptor control
    output logic                          function_connect,
    output logic                          billboard_mode,
    output logic                          alt_string_serve,
    output logic      [1:0]               config_result,
    output logic      [15:0]              bcd_version
);

    localparam logic [31:0] DETACH_LAST = 32'(DETACH_CYCLES - 1);

    bbs_state_t                state;
    bbs_state_t                next_state;
    logic [5:0]                control;
    logic [7:0]                ta_low;
    logic [7:0]                ta_high;
    logic [7:0]                tb_low;
    logic [7:0]                tb_high;
    logic [BBS_PIN_COUNT-1:0]  gpio_meta;
    logic [BBS_PIN_COUNT-1:0]  gpio_sync;
    logic                      pin_level;
    logic                      armed;
    logic [31:0]               detach_count;
    logic                      detach_done;
    logic                      in_session;
    logic                      timer_a_running;
    logic                      timer_b_running;
    logic                      timer_a_expired;
    logic                      timer_b_expired;
    logic                      reg_write;
    logic                      reg_read;
    logic [14:0]               reg_index;

    // ****************************************
    // helpers
    // ****************************************
    // unselectable codes behave as an idle (high) pin
    function automatic logic select_pin(input logic [4:0] code, input logic [BBS_PIN_COUNT-1:0] pins);
        logic level;
        level = 1'b1;
        if (code != BBS_SEL_RESERVED && code <= BBS_SEL_LAST) begin
            level = pins[code];
        end
        return level;
    endfunction

    // ****************************************
    // register port
    // ****************************************
    assign reg_index = address[16:2];
    assign reg_write = write_strobe && (address[1:0] == 2'h0);
    assign reg_read  = read_strobe && (address[1:0] == 2'h0);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control <= BBS_CTRL_RESET[5:0];
            ta_low  <= BBS_TA_LOW_RESET;
            ta_high <= BBS_TA_HIGH_RESET;
            tb_low  <= BBS_TB_LOW_RESET;
            tb_high <= BBS_TB_HIGH_RESET;
        end else if (reg_write) begin
            case (reg_index)
                BBS_IDX_CONTROL: begin
                    control <= write_data[5:0];
                end
                BBS_IDX_TA_LOW: begin
                    ta_low <= write_data;
                end
                BBS_IDX_TA_HIGH: begin
                    ta_high <= write_data;
                end
                BBS_IDX_TB_LOW: begin
                    tb_low <= write_data;
                end
                BBS_IDX_TB_HIGH: begin
                    tb_high <= write_data;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data <= 8'h00;
        end else if (reg_read) begin
            case (reg_index)
                BBS_IDX_CONTROL: begin
                    read_data <= {2'h0, control};
                end
                BBS_IDX_TA_LOW: begin
                    read_data <= ta_low;
                end
                BBS_IDX_TA_HIGH: begin
                    read_data <= ta_high;
                end
                BBS_IDX_TB_LOW: begin
                    read_data <= tb_low;
                end
                BBS_IDX_TB_HIGH: begin
                    read_data <= tb_high;
                end
                BBS_IDX_STATUS: begin
                    read_data <= {2'h0, armed, timer_b_running, timer_a_running,
                                  pin_level, function_connect, billboard_mode};
                end
                default: begin
                    read_data <= 8'h00;
                end
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end

    // ****************************************
    // failure input synchroniser and selection
    // ****************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            gpio_meta <= '1;
            gpio_sync <= '1;
        end else begin
            gpio_meta <= gpio_in;
            gpio_sync <= gpio_meta;
        end
    end

    assign pin_level = select_pin(control[BBS_CTRL_SEL_MSB:BBS_CTRL_SEL_LSB], gpio_sync);

    // a pin held low after a session must go high before it can start another
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            armed <= 1'b1;
        end else if (pin_level) begin
            armed <= 1'b1;
        end else if (state == BBS_DETACH_TO_BB) begin
            armed <= 1'b0;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    assign detach_done = (detach_count == DETACH_LAST);

    always_comb begin
        next_state = state;
        case (state)
            BBS_NORMAL: begin
                if (control[BBS_CTRL_ENABLE_BIT] && armed && !pin_level) begin
                    next_state = BBS_DETACH_TO_BB;
                end
            end
            BBS_DETACH_TO_BB: begin
                if (detach_done) begin
                    next_state = BBS_BB_ATTACHED;
                end
            end
            BBS_BB_ATTACHED: begin
                if (timer_a_expired || timer_b_expired || !control[BBS_CTRL_ENABLE_BIT]) begin
                    next_state = BBS_DETACH_TO_STD;
                end
            end
            BBS_DETACH_TO_STD: begin
                if (detach_done) begin
                    next_state = BBS_NORMAL;
                end
            end
            default: begin
                next_state = BBS_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= BBS_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            detach_count <= 32'h0000_0000;
        end else if (next_state != state) begin
            detach_count <= 32'h0000_0000;
        end else if (state == BBS_DETACH_TO_BB || state == BBS_DETACH_TO_STD) begin
            detach_count <= detach_count + 32'h0000_0001;
        end
    end

    // ****************************************
    // outputs towards the internal function
    // ****************************************
    // billboard_mode also selects the otp-held message text for the descriptors
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            function_connect <= 1'b1;
            billboard_mode   <= 1'b0;
            alt_string_serve <= 1'b0;
            config_result    <= BBS_RESULT_UNSPECIFIED;
            bcd_version      <= BBS_BCD_VERSION;
        end else begin
            function_connect <= (next_state == BBS_NORMAL) || (next_state == BBS_BB_ATTACHED);
            billboard_mode   <= (next_state == BBS_BB_ATTACHED);
            alt_string_serve <= alt_string_request && (state == BBS_BB_ATTACHED);
            config_result    <= BBS_RESULT_UNSPECIFIED;
            bcd_version      <= BBS_BCD_VERSION;
        end
    end

    // ****************************************
    // detach timers
    // ****************************************
    assign in_session = (state == BBS_BB_ATTACHED);

    bbs_detach_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) timer_a (
        .clock   (clock),
        .reset   (reset),
        .clear   (!in_session),
        .start   (in_session && address_assigned),
        .limit   ({ta_high, ta_low}),
        .running (timer_a_running),
        .expired (timer_a_expired)
    );

    bbs_detach_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) timer_b (
        .clock   (clock),
        .reset   (reset),
        .clear   (!in_session),
        .start   (in_session && alt_string_request),
        .limit   ({tb_high, tb_low}),
        .running (timer_b_running),
        .expired (timer_b_expired)
    );

    // ****************************************
    // checks
    // ****************************************
    a_disabled_stays: assert property (@(posedge clock) disable iff (reset)
        (state == BBS_NORMAL && !control[BBS_CTRL_ENABLE_BIT]) |=> state == BBS_NORMAL)
        else $error("session started while feature disabled");

    a_pin_low_detach: assert property (@(posedge clock) disable iff (reset)
        (state == BBS_NORMAL && control[BBS_CTRL_ENABLE_BIT] && armed && !pin_level)
        |=> (state == BBS_DETACH_TO_BB) ##1 !function_connect)
        else $error("low failure input did not force a detach");

    a_detach_before_bb: assert property (@(posedge clock) disable iff (reset)
        $rose(billboard_mode) |-> $past(state) == BBS_DETACH_TO_BB && !$past(function_connect))
        else $error("billboard attach without prior detach");

    a_bb_descriptors: assert property (@(posedge clock) disable iff (reset)
        billboard_mode |-> function_connect && bcd_version == 16'h0110)
        else $error("billboard attach with wrong descriptor state");

    a_result_code: assert property (@(posedge clock) disable iff (reset)
        billboard_mode |-> config_result == 2'h0)
        else $error("configuration result not unspecified");

    a_timer_a_start: assert property (@(posedge clock) disable iff (reset)
        (in_session && address_assigned && !timer_a_expired && next_state == BBS_BB_ATTACHED) |=> timer_a_running)
        else $error("address assignment did not start timer a");

    a_timer_b_start: assert property (@(posedge clock) disable iff (reset)
        (in_session && alt_string_request && next_state == BBS_BB_ATTACHED) |=> alt_string_serve && timer_b_running)
        else $error("string request not served or timer b not started");

    a_expiry_detach: assert property (@(posedge clock) disable iff (reset)
        (in_session && (timer_a_expired || timer_b_expired)) |=> state == BBS_DETACH_TO_STD && !function_connect)
        else $error("timer expiry did not force a detach");

    a_std_reattach: assert property (@(posedge clock) disable iff (reset)
        ($past(state) == BBS_DETACH_TO_STD && state == BBS_NORMAL) |-> function_connect && !billboard_mode)
        else $error("standard reattach wrong");

    a_timers_cleared: assert property (@(posedge clock) disable iff (reset)
        (state == BBS_NORMAL) |-> !timer_a_running && !timer_b_running)
        else $error("detach timer alive outside session");

endmodule

// [verilog/bbs_pkg.sv]
// package: register map, field layout, reset values and timing for the billboard mode sequencer
package bbs_pkg;

    // ****************************************
    // register indices (byte address is four times the index)
    // ****************************************
    localparam logic [14:0] BBS_IDX_CONTROL  = 15'h0004;
    localparam logic [14:0] BBS_IDX_TA_LOW   = 15'h413C;
    localparam logic [14:0] BBS_IDX_TA_HIGH  = 15'h413D;
    localparam logic [14:0] BBS_IDX_TB_LOW   = 15'h413E;
    localparam logic [14:0] BBS_IDX_TB_HIGH  = 15'h413F;
    localparam logic [14:0] BBS_IDX_STATUS   = 15'h4140;

    // ****************************************
    // control byte fields and reset values
    // ****************************************
    localparam int          BBS_CTRL_ENABLE_BIT = 0;
    localparam int          BBS_CTRL_SEL_LSB    = 1;
    localparam int          BBS_CTRL_SEL_MSB    = 5;
    localparam logic [7:0]  BBS_CTRL_RESET      = 8'h14;
    localparam logic [4:0]  BBS_SEL_RESERVED    = 5'h09;
    localparam logic [4:0]  BBS_SEL_LAST        = 5'h10;
    localparam int          BBS_PIN_COUNT       = 17;
    localparam logic [7:0]  BBS_TA_LOW_RESET    = 8'hD0;
    localparam logic [7:0]  BBS_TA_HIGH_RESET   = 8'h07;
    localparam logic [7:0]  BBS_TB_LOW_RESET    = 8'hD0;
    localparam logic [7:0]  BBS_TB_HIGH_RESET   = 8'h07;

    // ****************************************
    // descriptor constants
    // ****************************************
    localparam logic [1:0]  BBS_RESULT_UNSPECIFIED = 2'h0;
    localparam logic [15:0] BBS_BCD_VERSION        = 16'h0110;

    // ****************************************
    // timing
    // ****************************************
    localparam int BBS_CLOCK_KHZ       = 125000;
    localparam int BBS_TICK_MS         = 10;
    localparam int BBS_TICK_CYCLES     = BBS_TICK_MS * BBS_CLOCK_KHZ;
    localparam int BBS_DETACH_MS       = 10;
    localparam int BBS_DETACH_CYCLES   = BBS_DETACH_MS * BBS_CLOCK_KHZ;

    typedef enum logic [1:0] {
        BBS_NORMAL,
        BBS_DETACH_TO_BB,
        BBS_BB_ATTACHED,
        BBS_DETACH_TO_STD
    } bbs_state_t;

endpackage

// [verilog/bbs_detach_timer.sv]
// module: detach timer counting 10 ms ticks up to a programmable limit
`timescale 1ns/10ps
module bbs_detach_timer
    import bbs_pkg::*;
#(
    parameter int TICK_CYCLES = BBS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // control
    input  wire logic        clear,
    input  wire logic        start,
    input  wire logic [15:0] limit,
    // status
    output logic             running,
    output logic             expired
);

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    logic [31:0] prescale;
    logic [15:0] count;

    // ****************************************
    // counting
    // ****************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            running  <= 1'b0;
            expired  <= 1'b0;
            prescale <= 32'h0000_0000;
            count    <= 16'h0000;
        end else if (clear) begin
            running  <= 1'b0;
            expired  <= 1'b0;
            prescale <= 32'h0000_0000;
            count    <= 16'h0000;
        end else begin
            expired <= 1'b0;
            if (start && !running) begin
                running  <= 1'b1;
                prescale <= 32'h0000_0000;
                count    <= 16'h0000;
            end else if (running) begin
                if (count == limit) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else if (prescale == TICK_LAST) begin
                    prescale <= 32'h0000_0000;
                    count    <= count + 16'h0001;
                end else begin
                    prescale <= prescale + 32'h0000_0001;
                end
            end
        end
    end

    a_expire_stops: assert property (@(posedge clock) disable iff (reset)
        expired |-> !running)
        else $error("timer still running after expiry");

endmodule

// [dv/bbs_far_side_model.sv]
// partner model: failure pin of the power delivery controller and enumeration events of the host
`timescale 1ns/10ps
module bbs_far_side_model
    import bbs_pkg::*;
(
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset,
    // commands from the bench
    input  wire logic [4:0]               fail_pin,
    input  wire logic                     fail_report,
    input  wire logic                     assign_cmd,
    input  wire logic                     string_cmd,
    // view of the internal function
    input  wire logic                     function_connect,
    input  wire logic                     billboard_mode,
    // pins and events toward the block
    output logic      [BBS_PIN_COUNT-1:0] gpio_in,
    output logic                          address_assigned,
    output logic                          alt_string_request
);
    logic assign_pend;
    logic string_pend;
    logic enumerated;

    // ****************************************
    // failure pin, others idle high on pull-ups
    // ****************************************
    always_comb begin
        gpio_in = '1;
        if (fail_report && (fail_pin < BBS_PIN_COUNT)) begin
            gpio_in[fail_pin] = 1'b0;
        end
    end

    // ****************************************
    // host only talks to an attached billboard function
    // ****************************************
    assign enumerated = function_connect && billboard_mode;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            assign_pend        <= 1'b0;
            string_pend        <= 1'b0;
            address_assigned   <= 1'b0;
            alt_string_request <= 1'b0;
        end else begin
            address_assigned   <= assign_pend && enumerated && !address_assigned;
            alt_string_request <= string_pend && enumerated && !alt_string_request;
            assign_pend        <= assign_cmd || (assign_pend && !(enumerated && !address_assigned));
            string_pend        <= string_cmd || (string_pend && !(enumerated && !alt_string_request));
        end
    end
endmodule

// [dv/testbench.sv]
// testbench: register access, failure detach, billboard sessions and detach timer expiry
`timescale 1ns/10ps
module testbench;
    import bbs_pkg::*;

    localparam int TICK = 4;
    localparam int DET  = 3;

    logic                     clock;
    logic                     reset;
    logic [16:0]              address;
    logic [7:0]               write_data;
    logic                     write_strobe;
    logic                     read_strobe;
    logic [7:0]               read_data;
    logic [BBS_PIN_COUNT-1:0] gpio_in;
    logic                     address_assigned;
    logic                     alt_string_request;
    logic                     function_connect;
    logic                     billboard_mode;
    logic                     alt_string_serve;
    logic [1:0]               config_result;
    logic [15:0]              bcd_version;
    logic [4:0]               fail_pin;
    logic                     fail_report;
    logic                     assign_cmd;
    logic                     string_cmd;
    logic [4:0]               sel;
    int                       fails;
    int                       checks;
    int                       n;

    bbs_sequencer #(.TICK_CYCLES(TICK), .DETACH_CYCLES(DET)) u_bbs_sequencer (
        .clock(clock), .reset(reset), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .gpio_in(gpio_in), .address_assigned(address_assigned), .alt_string_request(alt_string_request),
        .function_connect(function_connect), .billboard_mode(billboard_mode),
        .alt_string_serve(alt_string_serve), .config_result(config_result), .bcd_version(bcd_version));

    bbs_far_side_model u_bbs_far_side_model (
        .clock(clock), .reset(reset), .fail_pin(fail_pin), .fail_report(fail_report),
        .assign_cmd(assign_cmd), .string_cmd(string_cmd), .function_connect(function_connect),
        .billboard_mode(billboard_mode), .gpio_in(gpio_in), .address_assigned(address_assigned),
        .alt_string_request(alt_string_request));

    // ****************************************
    // helpers
    // ****************************************
    task automatic test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic in_range(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr(input logic [14:0] idx, input logic [7:0] data);
        @(posedge clock);
        address      <= {idx, 2'b00};
        write_data   <= data;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [14:0] idx, input logic [7:0] exp, input string what);
        @(posedge clock);
        address     <= {idx, 2'b00};
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, read_data});
    endtask

    // counts edges until function_connect reaches the level
    task automatic wait_conn(input logic level, output int cycles);
        cycles = 0;
        while (function_connect !== level) begin
            @(posedge clock);
            #1;
            cycles++;
            if (cycles > 300) begin
                fails++;
                $display("BAD function_connect expected %b seen %b", level, function_connect);
                test_done();
            end
        end
    endtask

    // asks the host for an address or the string and waits for the event
    task automatic host_cmd(input bit str);
        int k;
        k = 0;
        @(posedge clock);
        assign_cmd <= !str;
        string_cmd <= str;
        @(posedge clock);
        assign_cmd <= 1'b0;
        string_cmd <= 1'b0;
        #1;
        while ((str ? alt_string_request : address_assigned) !== 1'b1) begin
            @(posedge clock);
            #1;
            k++;
            if (k > 50) begin
                fails++;
                $display("BAD host event expected 1 seen 0");
                test_done();
            end
        end
    endtask

    task automatic start_session;
        @(posedge clock);
        fail_report <= 1'b1;
        #1;
        wait_conn(1'b0, n);
        in_range("detach delay", 2, 6, n);
        chk("billboard_mode in detach", 16'h0000, {15'h0000, billboard_mode});
        wait_conn(1'b1, n);
        in_range("detach length", DET, DET + 1, n);
        chk("billboard_mode", 16'h0001, {15'h0000, billboard_mode});
        chk("bcd_version", 16'h0110, bcd_version);
        chk("config_result", 16'h0000, {14'h0000, config_result});
    endtask

    task automatic end_check;
        wait_conn(1'b1, n);
        in_range("end detach length", DET, DET + 1, n);
        chk("billboard_mode after", 16'h0000, {15'h0000, billboard_mode});
        @(posedge clock);
        fail_report <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
    endtask

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset        = 1'b1;
        address      = '0;
        write_data   = '0;
        write_strobe = 1'b0;
        read_strobe  = 1'b0;
        fail_pin     = 5'h0A;
        fail_report  = 1'b0;
        assign_cmd   = 1'b0;
        string_cmd   = 1'b0;
        fails        = 0;
        checks       = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        #1;
        chk("function_connect", 16'h0001, {15'h0000, function_connect});
        chk("billboard_mode", 16'h0000, {15'h0000, billboard_mode});
        chk("bcd_version", 16'h0110, bcd_version);
        rd(BBS_IDX_CONTROL, 8'h14, "control");
        rd(BBS_IDX_TA_LOW, 8'hD0, "timer_a_low");
        rd(BBS_IDX_TA_HIGH, 8'h07, "timer_a_high");
        rd(BBS_IDX_TB_LOW, 8'hD0, "timer_b_low");
        rd(BBS_IDX_TB_HIGH, 8'h07, "timer_b_high");
        rd(BBS_IDX_STATUS, 8'h26, "status idle");
        wr(BBS_IDX_CONTROL, 8'hFF);
        rd(BBS_IDX_CONTROL, 8'h3F, "control reserved bits");
        rd(15'h0005, 8'h00, "unmapped");
        // default control leaves the feature off
        wr(BBS_IDX_CONTROL, 8'h14);
        fail_report <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        chk("function_connect disabled", 16'h0001, {15'h0000, function_connect});
        fail_report <= 1'b0;
        // reserved code selects no pin
        wr(BBS_IDX_CONTROL, 8'h13);
        fail_pin    <= 5'h09;
        fail_report <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        chk("function_connect reserved", 16'h0001, {15'h0000, function_connect});
        fail_report <= 1'b0;
        // every valid code, session ended by disabling
        for (int code = 0; code < 17; code++) begin
            if (code == 9) continue;
            sel = code[4:0];
            fail_pin <= sel;
            wr(BBS_IDX_CONTROL, {2'b00, sel, 1'b1});
            start_session();
            wr(BBS_IDX_CONTROL, {2'b00, sel, 1'b0});
            wait_conn(1'b0, n);
            end_check();
        end
        wr(BBS_IDX_TA_LOW, 8'h02);
        wr(BBS_IDX_TA_HIGH, 8'h00);
        wr(BBS_IDX_TB_LOW, 8'h03);
        wr(BBS_IDX_TB_HIGH, 8'h00);
        wr(BBS_IDX_CONTROL, 8'h15);
        fail_pin <= 5'h0A;
        // timer A from address assignment
        start_session();
        host_cmd(1'b0);
        wait_conn(1'b0, n);
        in_range("timer a expiry", 2 * TICK + 1, 2 * TICK + 4, n);
        end_check();
        // timer B from the string request
        start_session();
        rd(BBS_IDX_STATUS, 8'h03, "status in session");
        host_cmd(1'b1);
        @(posedge clock);
        #1;
        chk("alt_string_serve", 16'h0001, {15'h0000, alt_string_serve});
        wait_conn(1'b0, n);
        in_range("timer b expiry", 3 * TICK, 3 * TICK + 3, n);
        end_check();
        // timer A cut short, next session counts from zero
        wr(BBS_IDX_TA_LOW, 8'h03);
        start_session();
        host_cmd(1'b0);
        rd(BBS_IDX_STATUS, 8'h0B, "status timer a");
        repeat (4) @(posedge clock);
        wr(BBS_IDX_CONTROL, 8'h14);
        wait_conn(1'b0, n);
        end_check();
        wr(BBS_IDX_CONTROL, 8'h15);
        start_session();
        host_cmd(1'b0);
        wait_conn(1'b0, n);
        in_range("timer a restart", 3 * TICK + 1, 3 * TICK + 4, n);
        end_check();
        test_done();
    end
endmodule
